// ### core/rctu_top.sv
`include "rctu_params.svh"
module rctu_top #(
   parameter int PC_W        = 13,
   parameter int TMR_W       = 24,
   parameter int POWERUP_TIMER_CYCLES = `RCTU_POWERUP_TIMER_CYCLES,
   parameter int OST_CYCLES  = `RCTU_OST_TOSC
) (
   input  wire logic            I_CLK,
   input  wire logic            I_RSTN,
   input  wire logic [11:0]     I_AWADDR,
   input  wire logic            I_AWVALID,
   output logic                 O_AWREADY,
   input  wire logic [31:0]     I_WDATA,
   input  wire logic [3:0]      I_WSTRB,
   input  wire logic            I_WVALID,
   output logic                 O_WREADY,
   output logic [1:0]           O_BRESP,
   output logic                 O_BVALID,
   input  wire logic            I_BREADY,
   input  wire logic [11:0]     I_ARADDR,
   input  wire logic            I_ARVALID,
   output logic                 O_ARREADY,
   output logic [31:0]          O_RDATA,
   output logic [1:0]           O_RRESP,
   output logic                 O_RVALID,
   input  wire logic            I_RREADY,
   input  wire logic            I_POR_EVT,
   input  wire logic            I_BOR_EVT,
   input  wire logic            I_MASTER_CLEAR_N_EVT,
   input  wire logic            I_WATCHDOG_EVT,
   input  wire logic            I_IRQ_WAKE_EVT,
   input  wire logic            I_SLEEP,
   input  wire logic            I_GLOBAL_IRQ_ENABLE,
   input  wire logic            I_INSTR_DONE,
   input  wire logic [PC_W-1:0] I_CUR_PC,
   input  wire logic            I_BROWNOUT_ENABLE_CFG,
   input  wire logic            I_POWERUP_TIMER_DISABLE_CFG,
   input  wire logic [1:0]      I_OSC_MODE,
   output logic                 O_CORE_RESET,
   output logic                 O_WAKE_HOLD,
   output logic                 O_PC_LOAD,
   output logic [PC_W-1:0]      O_PC_VALUE,
   output logic                 O_IRQ
);

   if (PC_W < 3 || PC_W > 16) begin : g_chk_pc
      $error("PC_W must lie between 3 and 16");
   end
   if (POWERUP_TIMER_CYCLES < 1 || OST_CYCLES < 1 || POWERUP_TIMER_CYCLES >= (2 ** TMR_W) ||
       OST_CYCLES >= (2 ** TMR_W)) begin : g_chk_tmr
      $error("Delay counts do not fit the timer");
   end

   // Reset release through two flops
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Event gathering
   rctu_pkg::rctu_evt_t evt;
   logic                xtal;
   always_comb begin
      evt.por       = I_POR_EVT;
      evt.bor       = I_BOR_EVT & I_BROWNOUT_ENABLE_CFG & ~I_POR_EVT;
      evt.master_clear_n      = I_MASTER_CLEAR_N_EVT;
      evt.wdog_rst  = I_WATCHDOG_EVT & ~I_SLEEP;
      evt.wdog_wake = I_WATCHDOG_EVT & I_SLEEP;
      evt.irq_wake  = I_IRQ_WAKE_EVT & I_SLEEP;
   end
   assign xtal = (I_OSC_MODE != `RCTU_OSC_RES_CAP);

   // Bus slave state
   logic        aw_hold_reg, aw_hold_next;
   logic [11:0] awaddr_reg, awaddr_next;
   logic        w_hold_reg, w_hold_next;
   logic [31:0] wdata_reg, wdata_next;
   logic        wstrb0_reg, wstrb0_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic        wr_fire;
   logic [9:0]  wr_idx;
   logic [9:0]  rd_idx;
   logic        rd_fire;

   // Block registers
   logic [7:0] st_reg, st_next;
   logic [1:0] power_control_flags_reg, power_control_flags_next;
   logic [6:0] evs_reg, evs_next;
   logic [6:0] mask_reg, mask_next;
   logic       irq_reg, irq_next;
   logic [6:0] evs_set;

   // Sequencer
   rctu_pkg::rctu_state_t seq_reg, seq_next;
   logic                  wake_reg, wake_next;
   logic                  vec_reg, vec_next;
   logic                  pcl_reg, pcl_next;
   logic [PC_W-1:0]       pcv_reg, pcv_next;
   logic                  crst_reg, crst_next;
   logic                  whold_reg, whold_next;
   logic                  tmr_start;
   logic [TMR_W-1:0]      tmr_load;
   logic                  tmr_done;

   assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_idx  = awaddr_reg[11:2];
   assign rd_fire = I_ARVALID & ~rvalid_reg;
   assign rd_idx  = I_ARADDR[11:2];

   always_comb begin
      aw_hold_next = aw_hold_reg;
      awaddr_next  = awaddr_reg;
      w_hold_next  = w_hold_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (I_AWVALID && !aw_hold_reg) begin
         aw_hold_next = 1'b1;
         awaddr_next  = I_AWADDR;
      end
      if (I_WVALID && !w_hold_reg) begin
         w_hold_next = 1'b1;
         wdata_next  = I_WDATA;
         wstrb0_next = I_WSTRB[0];
      end
      if (bvalid_reg && I_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         case (wr_idx)
            `RCTU_IDX_CORE_STATUS, `RCTU_IDX_POWER_CTRL,
            `RCTU_IDX_EVT_STATUS, `RCTU_IDX_EVT_MASK: bresp_next = `RCTU_RESP_OKAY;
            default: bresp_next = `RCTU_RESP_SLVERR;
         endcase
      end
      if (rvalid_reg && I_RREADY) begin
         rvalid_next = 1'b0;
      end
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rresp_next  = `RCTU_RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         case (rd_idx)
            `RCTU_IDX_CORE_STATUS: rdata_next = {24'h00_0000, st_reg};
            `RCTU_IDX_POWER_CTRL:  rdata_next = {30'h0, power_control_flags_reg};
            `RCTU_IDX_EVT_STATUS:  rdata_next = {25'h0, evs_reg};
            `RCTU_IDX_EVT_MASK:    rdata_next = {25'h0, mask_reg};
            default:               rresp_next = `RCTU_RESP_SLVERR;
         endcase
      end
   end

   // Flag registers, hardware events beat software writes
   always_comb begin
      st_next   = st_reg;
      power_control_flags_next = power_control_flags_reg;
      mask_next = mask_reg;
      evs_next  = evs_reg;
      if (wr_fire && wstrb0_reg) begin
         case (wr_idx)
            `RCTU_IDX_CORE_STATUS: begin
               st_next = {wdata_reg[7:5], st_reg[4:3], wdata_reg[2:0]};
            end
            `RCTU_IDX_POWER_CTRL: power_control_flags_next = wdata_reg[1:0];
            `RCTU_IDX_EVT_MASK:   mask_next = wdata_reg[6:0];
            default: ;
         endcase
      end
      if (evt.por) begin
         st_next[7:5]             = 3'h0;
         st_next[`RCTU_TO_BIT]    = 1'b1;
         st_next[`RCTU_PD_BIT]    = 1'b1;
         power_control_flags_next[`RCTU_POR_BIT] = 1'b0;
      end else if (evt.bor) begin
         st_next[7:5]             = 3'h0;
         st_next[`RCTU_TO_BIT]    = 1'b1;
         st_next[`RCTU_PD_BIT]    = 1'b1;
         power_control_flags_next[`RCTU_BOR_BIT] = 1'b0;
      end else if (evt.master_clear_n) begin
         st_next[7:5] = 3'h0;
         if (I_SLEEP) begin
            st_next[`RCTU_TO_BIT] = 1'b1;
            st_next[`RCTU_PD_BIT] = 1'b0;
         end
      end else if (evt.wdog_rst) begin
         st_next[7:5]          = 3'h0;
         st_next[`RCTU_TO_BIT] = 1'b0;
      end else if (evt.wdog_wake) begin
         st_next[`RCTU_TO_BIT] = 1'b0;
         st_next[`RCTU_PD_BIT] = 1'b0;
      end else if (evt.irq_wake) begin
         st_next[`RCTU_TO_BIT] = 1'b1;
         st_next[`RCTU_PD_BIT] = 1'b0;
      end
      evs_set = {seq_reg != rctu_pkg::ST_RUN && seq_next == rctu_pkg::ST_RUN, evt.irq_wake,
                 evt.wdog_wake, evt.wdog_rst, evt.master_clear_n, evt.bor, evt.por};
      if (rd_fire && rd_idx == `RCTU_IDX_EVT_STATUS) begin
         evs_next = 7'h00;
      end
      evs_next = evs_next | evs_set;
      irq_next = |(evs_next & mask_next);
   end

   // Start-up and wake sequencer
   always_comb begin
      seq_next  = seq_reg;
      wake_next = wake_reg;
      vec_next  = vec_reg;
      pcl_next  = 1'b0;
      pcv_next  = pcv_reg;
      tmr_start = 1'b0;
      tmr_load  = '0;
      case (seq_reg)
         rctu_pkg::ST_POWERUP_TIMER: begin
            if (tmr_done) begin
               if (xtal) begin
                  seq_next  = rctu_pkg::ST_OST;
                  tmr_start = 1'b1;
                  tmr_load  = TMR_W'(OST_CYCLES);
               end else begin
                  seq_next = rctu_pkg::ST_HOLD;
               end
            end
         end
         rctu_pkg::ST_OST: begin
            if (tmr_done) begin
               seq_next = rctu_pkg::ST_HOLD;
            end
         end
         rctu_pkg::ST_HOLD: begin
            seq_next = rctu_pkg::ST_RUN;
            pcl_next = 1'b1;
            if (wake_reg) begin
               pcv_next = I_CUR_PC + {{(PC_W-1){1'b0}}, 1'b1};
            end else begin
               pcv_next = PC_W'(`RCTU_RESET_VECTOR);
            end
         end
         rctu_pkg::ST_RUN: begin
            if (vec_reg && I_INSTR_DONE) begin
               vec_next = 1'b0;
               pcl_next = 1'b1;
               pcv_next = PC_W'(`RCTU_IRQ_VECTOR);
            end
         end
         default: seq_next = rctu_pkg::ST_RUN;
      endcase
      if (evt.por || evt.bor) begin
         wake_next = 1'b0;
         vec_next  = 1'b0;
         if (evt.bor || !I_POWERUP_TIMER_DISABLE_CFG) begin
            seq_next  = rctu_pkg::ST_POWERUP_TIMER;
            tmr_start = 1'b1;
            tmr_load  = TMR_W'(POWERUP_TIMER_CYCLES);
         end else if (xtal) begin
            seq_next  = rctu_pkg::ST_OST;
            tmr_start = 1'b1;
            tmr_load  = TMR_W'(OST_CYCLES);
         end else begin
            seq_next = rctu_pkg::ST_HOLD;
         end
      end else if (evt.master_clear_n || evt.wdog_rst) begin
         seq_next  = rctu_pkg::ST_HOLD;
         wake_next = 1'b0;
         vec_next  = 1'b0;
      end else if (evt.wdog_wake || evt.irq_wake) begin
         wake_next = 1'b1;
         vec_next  = evt.irq_wake & I_GLOBAL_IRQ_ENABLE;
         if (xtal) begin
            seq_next  = rctu_pkg::ST_OST;
            tmr_start = 1'b1;
            tmr_load  = TMR_W'(OST_CYCLES);
         end else begin
            seq_next = rctu_pkg::ST_HOLD;
         end
      end
      crst_next  = (seq_next != rctu_pkg::ST_RUN) & ~wake_next;
      whold_next = (seq_next != rctu_pkg::ST_RUN) & wake_next;
   end

   rctu_delay_timer #(
      .W (TMR_W)
   ) u_timer (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n),
      .i_start (tmr_start),
      .i_load  (tmr_load),
      .o_done  (tmr_done),
      .o_busy  ()
   );

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= 12'h000;
         w_hold_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb0_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= 2'h0;
         st_reg      <= `RCTU_CORE_STATUS_RST;
         power_control_flags_reg    <= `RCTU_POWER_CTRL_RST;
         evs_reg     <= 7'h00;
         mask_reg    <= `RCTU_EVT_MASK_RST;
         irq_reg     <= 1'b0;
         seq_reg     <= rctu_pkg::ST_HOLD;
         wake_reg    <= 1'b0;
         vec_reg     <= 1'b0;
         pcl_reg     <= 1'b0;
         pcv_reg     <= '0;
         crst_reg    <= 1'b1;
         whold_reg   <= 1'b0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         awaddr_reg  <= awaddr_next;
         w_hold_reg  <= w_hold_next;
         wdata_reg   <= wdata_next;
         wstrb0_reg  <= wstrb0_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         st_reg      <= st_next;
         power_control_flags_reg    <= power_control_flags_next;
         evs_reg     <= evs_next;
         mask_reg    <= mask_next;
         irq_reg     <= irq_next;
         seq_reg     <= seq_next;
         wake_reg    <= wake_next;
         vec_reg     <= vec_next;
         pcl_reg     <= pcl_next;
         pcv_reg     <= pcv_next;
         crst_reg    <= crst_next;
         whold_reg   <= whold_next;
      end
   end

   assign O_AWREADY    = ~aw_hold_reg;
   assign O_WREADY     = ~w_hold_reg;
   assign O_BVALID     = bvalid_reg;
   assign O_BRESP      = bresp_reg;
   assign O_ARREADY    = ~rvalid_reg;
   assign O_RVALID     = rvalid_reg;
   assign O_RDATA      = rdata_reg;
   assign O_RRESP      = rresp_reg;
   assign O_CORE_RESET = crst_reg;
   assign O_WAKE_HOLD  = whold_reg;
   assign O_PC_LOAD    = pcl_reg;
   assign O_PC_VALUE   = pcv_reg;
   assign O_IRQ        = irq_reg;

endmodule : rctu_top

// ### inc/rctu_params.svh
`ifndef RCTU_PARAMS_SVH
`define RCTU_PARAMS_SVH

// Register indices; byte address is four times the index
`define RCTU_IDX_CORE_STATUS   10'h083
`define RCTU_IDX_POWER_CTRL    10'h08E
`define RCTU_IDX_EVT_STATUS    10'h090
`define RCTU_IDX_EVT_MASK      10'h091

// Field positions
`define RCTU_TO_BIT            4
`define RCTU_PD_BIT            3
`define RCTU_POR_BIT           1
`define RCTU_BOR_BIT           0

// Reset values
`define RCTU_CORE_STATUS_RST   8'h18
`define RCTU_POWER_CTRL_RST    2'h0
`define RCTU_EVT_MASK_RST      7'h00

// Program counter targets
`define RCTU_RESET_VECTOR      16'h0000
`define RCTU_IRQ_VECTOR        16'h0004

// Oscillator mode codes
`define RCTU_OSC_LOW_POWER     2'h0
`define RCTU_OSC_CRYSTAL       2'h1
`define RCTU_OSC_HIGH_SPEED    2'h2
`define RCTU_OSC_RES_CAP       2'h3

// Timing
`define RCTU_CLK_KHZ           200000
`define RCTU_POWERUP_TIMER_MS           72
`define RCTU_POWERUP_TIMER_CYCLES       (`RCTU_POWERUP_TIMER_MS * `RCTU_CLK_KHZ)
`define RCTU_OST_TOSC          1024

// Bus answers
`define RCTU_RESP_OKAY         2'h0
`define RCTU_RESP_SLVERR       2'h2

`endif

// ### inc/rctu_pkg.sv
package rctu_pkg;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_HOLD,
      ST_POWERUP_TIMER,
      ST_OST
   } rctu_state_t;

   typedef struct packed {
      logic irq_wake;
      logic wdog_wake;
      logic wdog_rst;
      logic master_clear_n;
      logic bor;
      logic por;
   } rctu_evt_t;

endpackage : rctu_pkg

// ### core/rctu_delay_timer.sv
module rctu_delay_timer #(
   parameter int W = 24
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_start,
   input  wire logic [W-1:0] i_load,
   output logic              o_done,
   output logic              o_busy
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic         done_reg;
   logic         done_next;

   always_comb begin
      count_next = count_reg;
      done_next  = 1'b0;
      if (i_start) begin
         count_next = i_load;
      end else if (count_reg != '0) begin
         count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
         done_next  = (count_reg == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg  <= done_next;
      end
   end

   assign o_done = done_reg;
   assign o_busy = (count_reg != '0);

endmodule : rctu_delay_timer

// ### sim/rctu_core_model.sv
module rctu_core_model #(
   parameter int PC_W = 13
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_sleep_req,
   input  wire logic            i_core_reset,
   input  wire logic            i_wake_hold,
   input  wire logic            i_pc_load,
   input  wire logic [PC_W-1:0] i_pc_value,
   output logic                 o_sleep,
   output logic                 o_instr_done,
   output logic [PC_W-1:0]      o_cur_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sleep <= 1'b0;
         o_instr_done <= 1'b0;
         o_cur_pc <= '0;
         ph <= 1'b0;
      end else if (i_pc_load) begin
         o_cur_pc <= i_pc_value;
         o_sleep <= 1'b0;
         o_instr_done <= 1'b0;
         ph <= 1'b0;
      end else if (i_core_reset | i_wake_hold | o_sleep) begin
         o_instr_done <= 1'b0;
      end else begin
         ph <= ~ph;
         o_instr_done <= ph;
         o_cur_pc <= o_cur_pc + PC_W'(ph);
         o_sleep <= i_sleep_req;
      end
   end
endmodule : rctu_core_model

// ### sim/rctu_properties.sv
module rctu_chk #(
   parameter int PC_W = 13
) (
   input wire logic            I_CLK,
   input wire logic            I_RSTN,
   input wire logic            I_POR_EVT,
   input wire logic            I_BOR_EVT,
   input wire logic            I_MASTER_CLEAR_N_EVT,
   input wire logic            I_WATCHDOG_EVT,
   input wire logic            I_IRQ_WAKE_EVT,
   input wire logic            I_SLEEP,
   input wire logic            I_GLOBAL_IRQ_ENABLE,
   input wire logic            I_INSTR_DONE,
   input wire logic [PC_W-1:0] I_CUR_PC,
   input wire logic            I_BROWNOUT_ENABLE_CFG,
   input wire logic            I_POWERUP_TIMER_DISABLE_CFG,
   input wire logic            O_CORE_RESET,
   input wire logic            O_WAKE_HOLD,
   input wire logic            O_PC_LOAD,
   input wire logic [PC_W-1:0] O_PC_VALUE
);
   logic            rst_evt, wake_evt, wake_pend, vec_arm, gie_cap;
   logic [PC_W-1:0] wake_pc;
   assign rst_evt = I_POR_EVT | (I_BOR_EVT & I_BROWNOUT_ENABLE_CFG) | I_MASTER_CLEAR_N_EVT
                    | (I_WATCHDOG_EVT & ~I_SLEEP);
   assign wake_evt = (I_IRQ_WAKE_EVT | I_WATCHDOG_EVT) & I_SLEEP;
   // Tracks a pending wake and the vector jump it may owe
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wake_pend <= 1'b0;
         vec_arm <= 1'b0;
         gie_cap <= 1'b0;
         wake_pc <= '0;
      end else if (rst_evt) begin
         wake_pend <= 1'b0;
         vec_arm <= 1'b0;
      end else if (wake_evt) begin
         wake_pend <= 1'b1;
         gie_cap <= I_GLOBAL_IRQ_ENABLE & I_IRQ_WAKE_EVT;
         wake_pc <= I_CUR_PC;
      end else if (O_PC_LOAD) begin
         wake_pend <= 1'b0;
         vec_arm <= wake_pend & gie_cap;
      end else if (I_INSTR_DONE) begin
         vec_arm <= 1'b0;
      end
   end
   default clocking dcb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   a_master_clear_n_seq: assert property (
      (I_MASTER_CLEAR_N_EVT && !I_POR_EVT && !(I_BOR_EVT && I_BROWNOUT_ENABLE_CFG)) ##1 !rst_evt
      && !wake_evt |-> O_CORE_RESET ##1 (!O_CORE_RESET && O_PC_LOAD && O_PC_VALUE == '0))
      else $error("master clear sequence wrong");
   a_reset_vector: assert property (
      O_PC_LOAD && $past(O_CORE_RESET) |-> O_PC_VALUE == '0)
      else $error("reset pc not zero");
   a_wake_pc_next: assert property (
      O_PC_LOAD && wake_pend |-> O_PC_VALUE == PC_W'(wake_pc + 1'b1))
      else $error("wake pc not pc plus one");
   a_vector_jump: assert property (
      vec_arm && I_INSTR_DONE && !rst_evt |=> O_PC_LOAD && O_PC_VALUE == PC_W'(4))
      else $error("interrupt vector not loaded");
   a_wake_no_reset: assert property (
      wake_evt && !rst_evt && !O_CORE_RESET |=> !O_CORE_RESET)
      else $error("wake asserted core reset");
   a_bor_ignored: assert property (
      I_BOR_EVT && !I_BROWNOUT_ENABLE_CFG && !rst_evt && !wake_evt && !O_CORE_RESET
      && !O_WAKE_HOLD |=> !O_CORE_RESET && !O_WAKE_HOLD)
      else $error("disabled brown-out acted");
   a_por_holds: assert property (
      I_POR_EVT && !I_POWERUP_TIMER_DISABLE_CFG |=> O_CORE_RESET [*8])
      else $error("power-on hold too short");
   a_wdog_reset: assert property (
      I_WATCHDOG_EVT && !I_SLEEP |=> O_CORE_RESET)
      else $error("watchdog reset missing");
   c_por_done: cover property ($fell(O_CORE_RESET));
   c_wake_load: cover property (O_PC_LOAD && wake_pend);
   c_vector: cover property (vec_arm && I_INSTR_DONE);
endmodule : rctu_chk

bind rctu_top rctu_chk #(.PC_W(PC_W)) u_chk (.I_CLK, .I_RSTN, .I_POR_EVT, .I_BOR_EVT,
   .I_MASTER_CLEAR_N_EVT, .I_WATCHDOG_EVT, .I_IRQ_WAKE_EVT, .I_SLEEP, .I_GLOBAL_IRQ_ENABLE,
   .I_INSTR_DONE, .I_CUR_PC, .I_BROWNOUT_ENABLE_CFG, .I_POWERUP_TIMER_DISABLE_CFG,
   .O_CORE_RESET, .O_WAKE_HOLD, .O_PC_LOAD, .O_PC_VALUE);

// ### sim/tb.sv
`include "rctu_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POWERUP_TIMER = 20;
   localparam int OSC_STARTUP_TIMER  = 8;
   localparam logic [11:0] A_ST = 12'(`RCTU_IDX_CORE_STATUS * 4);
   localparam logic [11:0] A_PC = 12'(`RCTU_IDX_POWER_CTRL * 4);
   localparam logic [11:0] A_EV = 12'(`RCTU_IDX_EVT_STATUS * 4);
   localparam logic [11:0] A_MK = 12'(`RCTU_IDX_EVT_MASK * 4);
   localparam logic [1:0]  OK = `RCTU_RESP_OKAY;
   localparam logic [1:0]  SE = `RCTU_RESP_SLVERR;
   localparam rctu_pkg::rctu_evt_t POR = 6'h01, BOR = 6'h02, MCL = 6'h04;
   localparam rctu_pkg::rctu_evt_t WDR = 6'h08, WDW = 6'h10, IRQ = 6'h20;
   rctu_pkg::rctu_evt_t tev [7] = '{POR, POR, POR, POR, BOR, WDW, IRQ};
   logic [1:0]  tosc [7] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h0, 2'h2, 2'h3};
   logic        tpd [7]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic        I_CLK, I_RSTN = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
   logic        I_ARVALID = 0, I_RREADY = 0, sleep_req = 0, I_GLOBAL_IRQ_ENABLE = 0;
   logic        I_BROWNOUT_ENABLE_CFG = 1, I_POWERUP_TIMER_DISABLE_CFG = 0;
   logic [11:0] I_AWADDR = '0, I_ARADDR = '0;
   logic [31:0] I_WDATA = '0, seed = 32'hC5D8, O_RDATA;
   logic [3:0]  I_WSTRB = '0;
   logic [1:0]  I_OSC_MODE = `RCTU_OSC_CRYSTAL, O_BRESP, O_RRESP;
   logic [7:0]  st;
   logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CORE_RESET;
   logic        O_WAKE_HOLD, O_PC_LOAD, O_IRQ, I_SLEEP, I_INSTR_DONE;
   logic [12:0] O_PC_VALUE, I_CUR_PC;
   rctu_pkg::rctu_evt_t evt = '0;
   int          error_cnt = 0, total_checks = 0, n, d;

   rctu_top #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER), .OST_CYCLES(OSC_STARTUP_TIMER)) uut (.I_CLK, .I_RSTN, .I_AWADDR,
      .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID,
      .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY,
      .I_POR_EVT(evt.por), .I_BOR_EVT(evt.bor), .I_MASTER_CLEAR_N_EVT(evt.master_clear_n),
      .I_WATCHDOG_EVT(evt.wdog_rst | evt.wdog_wake), .I_IRQ_WAKE_EVT(evt.irq_wake), .I_SLEEP,
      .I_GLOBAL_IRQ_ENABLE, .I_INSTR_DONE, .I_CUR_PC, .I_BROWNOUT_ENABLE_CFG,
      .I_POWERUP_TIMER_DISABLE_CFG, .I_OSC_MODE, .O_CORE_RESET, .O_WAKE_HOLD, .O_PC_LOAD,
      .O_PC_VALUE, .O_IRQ);
   rctu_core_model core (.i_clk(I_CLK), .i_rst_n(I_RSTN), .i_sleep_req(sleep_req),
      .i_core_reset(O_CORE_RESET), .i_wake_hold(O_WAKE_HOLD), .i_pc_load(O_PC_LOAD),
      .i_pc_value(O_PC_VALUE), .o_sleep(I_SLEEP), .o_instr_done(I_INSTR_DONE),
      .o_cur_pc(I_CUR_PC));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   function automatic logic [7:0] exp_st(input logic [7:0] o, input logic [7:0] w);
      return (w & 8'hE7) | (o & 8'h18);
   endfunction : exp_st
   function automatic int exp_delay(input rctu_pkg::rctu_evt_t e, input logic [1:0] m,
                                    input logic pd);
      return ((e.por && !pd) || e.bor ? POWERUP_TIMER : 0) + (m != `RCTU_OSC_RES_CAP ? OSC_STARTUP_TIMER : 0);
   endfunction : exp_delay
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw, w;
      int k;
      aw = 0;
      w = 0;
      k = 0;
      I_AWADDR <= a;
      I_WDATA <= v;
      I_WSTRB <= s;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      while (!(aw && w) && k < 50) begin
         @(posedge I_CLK);
         k++;
         if (!aw && O_AWREADY === 1'b1) begin
            aw = 1;
            I_AWVALID <= 1'b0;
         end
         if (!w && O_WREADY === 1'b1) begin
            w = 1;
            I_WVALID <= 1'b0;
         end
      end
      I_BREADY <= 1'b1;
      do begin
         @(posedge I_CLK);
         k++;
      end while (O_BVALID !== 1'b1 && k < 100);
      I_BREADY <= 1'b0;
      check("bvalid", 32'(O_BVALID), 1);
      check("bresp", 32'(O_BRESP), 32'(er));
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
      int k;
      k = 0;
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      do begin
         @(posedge I_CLK);
         k++;
      end while (O_ARREADY !== 1'b1 && k < 50);
      I_ARVALID <= 1'b0;
      I_RREADY <= 1'b1;
      do begin
         @(posedge I_CLK);
         k++;
      end while (O_RVALID !== 1'b1 && k < 100);
      I_RREADY <= 1'b0;
      check("rvalid", 32'(O_RVALID), 1);
      check("rdata", O_RDATA & m, e);
      check("rresp", 32'(O_RRESP), 32'(er));
   endtask : rdc
   task automatic fire(input rctu_pkg::rctu_evt_t e, output int cyc);
      evt <= e;
      @(posedge I_CLK);
      evt <= '0;
      cyc = 0;
      do begin
         @(posedge I_CLK);
         cyc++;
      end while ((O_CORE_RESET | O_WAKE_HOLD) !== 1'b0 && cyc < 500);
      if (cyc >= 500) error_cnt++;
      repeat (3) @(posedge I_CLK);
   endtask : fire
   task automatic nap();
      sleep_req <= 1'b1;
      repeat (20) @(posedge I_CLK);
      sleep_req <= 1'b0;
      check("sleep", 32'(I_SLEEP), 1);
   endtask : nap

   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      repeat (4) @(posedge I_CLK);
      st = `RCTU_CORE_STATUS_RST;
      rdc(A_ST, 32'h18, 32'hFF, OK);
      rdc(A_PC, 0, 32'hFFFFFFFF, OK);
      rdc(A_MK, 0, 32'hFFFFFFFF, OK);
      rdc(12'h100, 0, 32'hFFFFFFFF, SE);
      wr(12'h100, 32'h1, 4'hF, SE);
      wr(A_ST, 32'hFF, 4'h0, OK);
      rdc(A_ST, 32'(st), 32'hFF, OK);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(A_ST, seed, 4'hF, OK);
         st = exp_st(st, seed[7:0]);
         rdc(A_ST, 32'(st), 32'hFF, OK);
         wr(A_PC, seed, 4'hF, OK);
         rdc(A_PC, 32'(seed[1:0]), 32'hFFFFFFFF, OK);
      end
      for (int i = 0; i < 7; i++) begin
         I_OSC_MODE <= tosc[i];
         I_POWERUP_TIMER_DISABLE_CFG <= tpd[i];
         if (tev[i].irq_wake || tev[i].wdog_wake) begin
            nap();
         end
         fire(tev[i], n);
         d = exp_delay(tev[i], tosc[i], tpd[i]);
         check("startup", 32'(n >= d && n <= d + 4), 1);
      end
      I_OSC_MODE <= `RCTU_OSC_CRYSTAL;
      evt <= BOR;
      @(posedge I_CLK);
      evt <= '0;
      repeat (10) @(posedge I_CLK);
      fire(BOR, n);
      check("restart", 32'(n >= POWERUP_TIMER + OSC_STARTUP_TIMER), 1);
      wr(A_PC, 3, 4'hF, OK);
      fire(POR, n);
      rdc(A_PC, 0, 32'h2, OK);
      rdc(A_ST, 32'h18, 32'hF8, OK);
      wr(A_PC, 3, 4'hF, OK);
      wr(A_ST, 32'hFF, 4'hF, OK);
      fire(MCL, n);
      rdc(A_ST, 32'h1F, 32'hFF, OK);
      rdc(A_PC, 3, 32'hFFFFFFFF, OK);
      fire(WDR, n);
      rdc(A_ST, 32'h0F, 32'hFF, OK);
      fire(BOR, n);
      rdc(A_PC, 2, 32'h3, OK);
      rdc(A_ST, 32'h07, 32'hE7, OK);
      wr(A_PC, 3, 4'hF, OK);
      I_BROWNOUT_ENABLE_CFG <= 1'b0;
      fire(BOR, n);
      I_BROWNOUT_ENABLE_CFG <= 1'b1;
      rdc(A_PC, 2, 32'h2, OK);
      wr(A_ST, 32'hA5, 4'hF, OK);
      nap();
      fire(WDW, n);
      rdc(A_ST, 32'hA5, 32'hFF, OK);
      I_GLOBAL_IRQ_ENABLE <= 1'b1;
      nap();
      fire(IRQ, n);
      rdc(A_ST, 32'hB5, 32'hFF, OK);
      repeat (10) @(posedge I_CLK);
      nap();
      fire(MCL, n);
      rdc(A_ST, 32'h15, 32'hFF, OK);
      rdc(A_EV, 0, 0, OK);
      wr(A_MK, 32'h7F, 4'hF, OK);
      fire(MCL, n);
      #1;
      check("irq", 32'(O_IRQ), 1);
      rdc(A_EV, 32'h44, 32'h7F, OK);
      repeat (2) @(posedge I_CLK);
      #1;
      check("irq", 32'(O_IRQ), 0);
      wr(A_MK, 0, 4'hF, OK);
      fire(MCL, n);
      #1;
      check("irq", 32'(O_IRQ), 0);
      rdc(A_EV, 32'h44, 32'h7F, OK);
      conclude();
   end
endmodule : tb
